//--- common/scm_pkg.sv
// Purpose: Shared constants and types for the supply channel status monitor.
// Assumes: One 10 MHz clock; all pin inputs synchronous to it.
// Notes:   Each offset, field position, reset value and timing count lives here once.
package scm_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MIN_CYCLE_TIME_US = 100;
    localparam int unsigned MIN_UPDATE_TIME_US = 1000;
    // Least times round up to whole cycles
    localparam int unsigned MIN_CYCLE_CYCLES =
        (MIN_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MIN_UPDATE_CYCLES =
        (MIN_UPDATE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Indicator timebase tick of one millisecond
    localparam int unsigned LED_TICK_TIME_US = 1000;
    localparam int unsigned LED_TICK_CYCLES = (LED_TICK_TIME_US * 1000) / CLK_PERIOD_NS;
    // Indicator patterns, counted in timebase ticks
    localparam logic [10:0] BLINK_HALF_TICKS = 11'h0c8;
    localparam logic [10:0] FLASH_ON_TICKS = 11'h0c8;
    localparam logic [10:0] FLASH_PERIOD_TICKS = 11'h4b0;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam int unsigned NUM_CH = 4;
    localparam logic [7:0] STATUS_IDX = 8'h00;
    localparam int unsigned SHORT_LSB = 0;
    localparam int unsigned OPEN_LSB = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] SLOTS_ON_CAN = 8'h01;

    typedef logic [7:0] unsigned_byte_type;

    // Function models presented to the controller
    typedef enum logic [7:0] {
        FM_STANDARD = 8'h00,
        FM_BUS_CTRL = 8'hfe
    } scm_fm_type;

    // Module error indicator states
    typedef enum logic [1:0] {
        ERR_DARK  = 2'b00,
        ERR_STEAD = 2'b01,
        ERR_FLASH = 2'b10
    } scm_err_type;

endpackage

//--- rtl/scm_led_pattern.sv
// Purpose: Blink and single-flash patterns for the indicators.
// Assumes: tick_i is a one-cycle pulse every millisecond.
// Notes:   Both patterns run freely; users pick them up when needed.
`timescale 1ns/1ps
module scm_led_pattern import scm_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    output logic blink_o,
    output logic flash_o
);

    // ----------------------------------------------------------------
    // Pattern counters
    // ----------------------------------------------------------------
    logic [10:0] blink_cnt_r, blink_cnt_nxt;
    logic [10:0] flash_cnt_r, flash_cnt_nxt;
    logic blink_r, blink_nxt;
    logic flash_r, flash_nxt;

    // Next values, advanced only on the millisecond tick
    always_comb begin
        blink_cnt_nxt = blink_cnt_r;
        flash_cnt_nxt = flash_cnt_r;
        blink_nxt = blink_r;
        flash_nxt = flash_r;
        if (tick_i) begin
            if (blink_cnt_r == BLINK_HALF_TICKS - 11'h001) begin
                blink_cnt_nxt = 11'h000;
                blink_nxt = ~blink_r;
            end else begin
                blink_cnt_nxt = blink_cnt_r + 11'h001;
            end
            if (flash_cnt_r == FLASH_PERIOD_TICKS - 11'h001) begin
                flash_cnt_nxt = 11'h000;
            end else begin
                flash_cnt_nxt = flash_cnt_r + 11'h001;
            end
            // One short flash at the start of each period
            flash_nxt = (flash_cnt_nxt < FLASH_ON_TICKS);
        end
    end

    // Registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blink_cnt_r <= 11'h000;
            flash_cnt_r <= 11'h000;
            blink_r <= 1'b0;
            flash_r <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            blink_r <= blink_nxt;
            flash_r <= flash_nxt;
        end
    end

    assign blink_o = blink_r;
    assign flash_o = flash_r;

endmodule

//--- rtl/scm_status_monitor.sv
// Purpose: Status register, indicators and output switching of a four channel
//          potentiometer supply.
// Assumes: Channel conditions arrive as synchronous levels; the controller
//          marks each bus cycle with a one-cycle pulse and reads by index.
// Notes:   Status refresh is paced by the minimum I/O update time.
//
// Functional notes
// - Status bits 0..3 show short circuit on channels 1..4, 1 while shorted.
// - Status bits 4..7 show open line on channels 1..4, 1 while unloaded.
// - Status byte sits at byte position 0 of the controller data object.
// - Bus controller model is default only behind non-configurable controllers.
// - Module takes exactly one digital logical slot on the CAN I/O bus.
// - Error indicator lit steadily on module error or while in reset.
// - Error indicator single-flashes while any channel is overloaded and no module error is present.
// - Channel indicator dark without power or on open line.
// - Overloaded channel has its output switched off and indicator blinking, or dark if its line is also open.
// - Channel indicator steadily lit with load present and normal operation.
// - Status refreshed each cycle only when cycles last 1 ms or longer.
// - Error indicator dark when unpowered or no fault present.
`timescale 1ns/1ps
module scm_status_monitor import scm_pkg::*; #(
    parameter int unsigned P_UPDATE_CYCLES = MIN_UPDATE_CYCLES,
    parameter int unsigned P_TICK_CYCLES = LED_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] ch_short_i,
    input wire logic [3:0] ch_open_i,
    input wire logic module_error_i,
    input wire logic fixed_ctrl_i,
    input wire logic cycle_start_i,
    input wire logic rd_stb_i,
    input wire logic [7:0] rd_idx_i,
    output logic rd_ack_o,
    output logic [7:0] rd_data_o,
    output logic [7:0] func_model_o,
    output logic [7:0] can_slots_o,
    output logic cycle_too_fast_o,
    output logic [3:0] ch_out_en_o,
    output logic [3:0] ch_led_o,
    output logic err_led_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Channel indicator decode, shared by every channel
    function automatic logic chan_led(input logic open_l, input logic short_l,
                                      input logic blink_l);
        if (open_l) begin
            chan_led = 1'b0;
        end else if (short_l) begin
            chan_led = blink_l;
        end else begin
            chan_led = 1'b1;
        end
    endfunction

    // ----------------------------------------------------------------
    // Millisecond timebase
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;
    logic blink_w, flash_w;

    // Single divider; both indicator patterns derive from this enable
    always_comb begin
        tick_nxt = 1'b0;
        if (tick_cnt_r == 16'(P_TICK_CYCLES - 1)) begin
            tick_cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end else begin
            tick_cnt_nxt = tick_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    scm_led_pattern u_pattern (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick_r),
        .blink_o(blink_w),
        .flash_o(flash_w)
    );

    // ----------------------------------------------------------------
    // Bus cycle pacing and status capture
    // ----------------------------------------------------------------
    logic [15:0] since_upd_r, since_upd_nxt;
    logic [15:0] since_cyc_r, since_cyc_nxt;
    logic [7:0] status_r, status_nxt;
    logic too_fast_r, too_fast_nxt;
    logic upd_ok;

    // Refresh only when a full update time has passed; faster cycles
    // see the previous snapshot, which keeps the byte self-consistent
    assign upd_ok = (since_upd_r >= 16'(P_UPDATE_CYCLES - 1));

    always_comb begin
        since_upd_nxt = since_upd_r;
        since_cyc_nxt = since_cyc_r;
        status_nxt = status_r;
        too_fast_nxt = too_fast_r;
        if (since_upd_r != 16'hffff) begin
            since_upd_nxt = since_upd_r + 16'h0001;
        end
        if (since_cyc_r != 16'hffff) begin
            since_cyc_nxt = since_cyc_r + 16'h0001;
        end
        if (cycle_start_i) begin
            since_cyc_nxt = 16'h0000;
            // Shorter cycles than allowed are flagged, not acted upon
            too_fast_nxt = (since_cyc_r < 16'(MIN_CYCLE_CYCLES - 1));
            if (upd_ok) begin
                since_upd_nxt = 16'h0000;
                // Present condition, nothing held from earlier faults
                status_nxt[SHORT_LSB +: NUM_CH] = ch_short_i;
                status_nxt[OPEN_LSB +: NUM_CH] = ch_open_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_upd_r <= 16'hffff;
            since_cyc_r <= 16'hffff;
            status_r <= STATUS_RESET;
            too_fast_r <= 1'b0;
        end else begin
            since_upd_r <= since_upd_nxt;
            since_cyc_r <= since_cyc_nxt;
            status_r <= status_nxt;
            too_fast_r <= too_fast_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Controller read port and identity
    // ----------------------------------------------------------------
    logic rd_ack_r, rd_ack_nxt;
    unsigned_byte_type rd_data_r, rd_data_nxt;
    scm_fm_type fm_r, fm_nxt;
    logic [7:0] slots_r;

    // Unmapped indices answer with zero so the controller never stalls
    always_comb begin
        rd_ack_nxt = rd_stb_i;
        rd_data_nxt = 8'h00;
        if (rd_stb_i && rd_idx_i == STATUS_IDX) begin
            rd_data_nxt = status_r;
        end
        fm_nxt = fixed_ctrl_i ? FM_BUS_CTRL : FM_STANDARD;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ack_r <= 1'b0;
            rd_data_r <= 8'h00;
            fm_r <= FM_STANDARD;
            slots_r <= 8'h00;
        end else begin
            rd_ack_r <= rd_ack_nxt;
            rd_data_r <= rd_data_nxt;
            fm_r <= fm_nxt;
            slots_r <= SLOTS_ON_CAN;
        end
    end

    // ----------------------------------------------------------------
    // Indicators and output switching
    // ----------------------------------------------------------------
    scm_err_type err_st;
    logic err_led_r, err_led_nxt;
    logic [3:0] ch_led_r, ch_led_nxt;
    logic [3:0] out_en_r, out_en_nxt;

    // Error state: hard error outranks the overload flash
    always_comb begin
        if (module_error_i) begin
            err_st = ERR_STEAD;
        end else if (|ch_short_i) begin
            err_st = ERR_FLASH;
        end else begin
            err_st = ERR_DARK;
        end
        unique case (err_st)
            ERR_STEAD: err_led_nxt = 1'b1;
            ERR_FLASH: err_led_nxt = flash_w;
            ERR_DARK: err_led_nxt = 1'b0;
            default: err_led_nxt = 1'b1;
        endcase
    end

    // Per channel: indicators track live condition, not the snapshot
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        always_comb begin
            ch_led_nxt[ch] = chan_led(ch_open_i[ch], ch_short_i[ch], blink_w);
            out_en_nxt[ch] = ~ch_short_i[ch];
        end
    end

    // Reset lights the error indicator and keeps outputs off
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_led_r <= 1'b1;
            ch_led_r <= 4'h0;
            out_en_r <= 4'h0;
        end else begin
            err_led_r <= err_led_nxt;
            ch_led_r <= ch_led_nxt;
            out_en_r <= out_en_nxt;
        end
    end

    assign rd_ack_o = rd_ack_r;
    assign rd_data_o = rd_data_r;
    assign func_model_o = fm_r;
    assign can_slots_o = slots_r;
    assign cycle_too_fast_o = too_fast_r;
    assign ch_out_en_o = out_en_r;
    assign ch_led_o = ch_led_r;
    assign err_led_o = err_led_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_short_bits_update: assert property (
        cycle_start_i && upd_ok |=> status_r[3:0] == $past(ch_short_i))
        else $error("short bits not refreshed");
    a_open_bits_update: assert property (
        cycle_start_i && upd_ok |=> status_r[7:4] == $past(ch_open_i))
        else $error("open bits not refreshed");
    a_fast_cycle_hold: assert property (
        cycle_start_i && !upd_ok |=> $stable(status_r))
        else $error("status refreshed too early");
    a_read_status_byte: assert property (
        rd_stb_i && rd_idx_i == 8'h00 |=> rd_ack_o && rd_data_o == $past(status_r))
        else $error("status byte read wrong");
    a_func_model_sel: assert property (
        fixed_ctrl_i ##1 fixed_ctrl_i |-> func_model_o == 8'hfe)
        else $error("bus controller model not selected");
    a_can_one_slot: assert property (
        $past(nrst_i) |-> can_slots_o == 8'h01)
        else $error("slot count wrong");
    a_err_led_steady: assert property (
        module_error_i [*2] |=> err_led_o)
        else $error("error indicator not lit");
    a_err_led_flash: assert property (
        !module_error_i && (|ch_short_i) |=> err_led_o == $past(flash_w))
        else $error("error indicator not flashing");
    a_err_led_dark: assert property (
        !module_error_i && ch_short_i == 4'h0 |=> !err_led_o)
        else $error("error indicator lit without fault");
    a_open_dark_led: assert property (
        ch_open_i[0] |=> !ch_led_o[0])
        else $error("open channel indicator lit");
    a_short_out_off: assert property (
        ch_short_i != 4'h0 |=> (ch_out_en_o & $past(ch_short_i)) == 4'h0)
        else $error("shorted output still enabled");
    a_normal_led_on: assert property (
        !ch_open_i[1] && !ch_short_i[1] |=> ch_led_o[1])
        else $error("loaded channel indicator dark");
    a_fault_clears: assert property (
        cycle_start_i && upd_ok && ch_short_i[2] == 1'b0 |=> !status_r[2])
        else $error("short bit latched");
    // Read port: one answer per request, nothing left on the data lines
    a_unmapped_read_zero: assert property (
        rd_stb_i && rd_idx_i != STATUS_IDX |=> rd_ack_o && rd_data_o == 8'h00)
        else $error("unmapped index returned data");
    a_idle_read_quiet: assert property (
        !rd_stb_i |=> !rd_ack_o && rd_data_o == 8'h00)
        else $error("answer without a request");
    // Outputs come back as soon as the overload is gone
    a_normal_out_on: assert property (
        !ch_short_i[3] |=> ch_out_en_o[3])
        else $error("healthy output switched off");
    // The pacing flag only moves when a bus cycle starts
    a_fast_flag_holds: assert property (
        !cycle_start_i |=> $stable(cycle_too_fast_o))
        else $error("cycle pacing flag moved between cycles");

    // Main scenarios the bench is expected to reach
    c_update_taken: cover property (cycle_start_i && upd_ok ##1 status_r != 8'h00);
    c_fast_cycle: cover property (cycle_start_i ##1 cycle_too_fast_o);
    c_update_skipped: cover property (cycle_start_i && !upd_ok);
    c_overload_flash: cover property (|ch_short_i && err_led_o);
    c_status_read: cover property (rd_stb_i ##1 rd_ack_o && rd_data_o != 8'h00);

endmodule

//--- dv/scm_ctrl_model.sv
// Purpose: Bus controller model that opens a bus cycle and reads one byte.
// Assumes: go_i is driven by nonblocking assignment at the falling edge.
// Notes:   Cycle spacing is left to the caller, so fast cycles are possible.
`timescale 1ns/1ps
module scm_ctrl_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic [7:0] idx_i,
    output logic cycle_start_o,
    output logic rd_stb_o,
    output logic [7:0] rd_idx_o
);
    logic [1:0] step_r;

    // ----------------------------------------------------------------
    // Cycle pulse, one idle cycle, then a single read strobe
    // ----------------------------------------------------------------
    // Driven off the sampling edge so the design never sees a moving request
    always @(negedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_r <= 2'd0;
            cycle_start_o <= 1'b0;
            rd_stb_o <= 1'b0;
            rd_idx_o <= 8'h5a;
        end else begin
            case (step_r)
                2'd0: begin
                    cycle_start_o <= go_i;
                    step_r <= go_i ? 2'd1 : 2'd0;
                end
                2'd1: begin
                    cycle_start_o <= 1'b0;
                    step_r <= 2'd2;
                end
                2'd2: begin
                    rd_stb_o <= 1'b1;
                    rd_idx_o <= idx_i;
                    step_r <= 2'd3;
                end
                default: begin
                    // Index no longer valid: show the inverse, not the old value
                    rd_stb_o <= 1'b0;
                    rd_idx_o <= ~rd_idx_o;
                    step_r <= 2'd0;
                end
            endcase
        end
    end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the supply channel status monitor.
// Assumes: Short update and tick parameters; inputs change at falling edges.
// Notes:   Read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module testbench import scm_pkg::*;;
    localparam int unsigned UPD = 20;
    localparam int unsigned TICK = 4;
    logic clk_i, nrst_i, module_error_i, fixed_ctrl_i, go, rd_ack_o, cycle_too_fast_o;
    logic cycle_start_i, rd_stb_i, err_led_o;
    logic [3:0] ch_short_i, ch_open_i, ch_out_en_o, ch_led_o;
    logic [7:0] idx, rd_idx_i, rd_data_o, func_model_o, can_slots_o, a, b;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int checked = 0;
    int seed = 17560;
    int n;

    scm_status_monitor #(.P_UPDATE_CYCLES(UPD), .P_TICK_CYCLES(TICK)) i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .ch_short_i(ch_short_i), .ch_open_i(ch_open_i),
        .module_error_i(module_error_i), .fixed_ctrl_i(fixed_ctrl_i),
        .cycle_start_i(cycle_start_i), .rd_stb_i(rd_stb_i), .rd_idx_i(rd_idx_i),
        .rd_ack_o(rd_ack_o), .rd_data_o(rd_data_o), .func_model_o(func_model_o),
        .can_slots_o(can_slots_o), .cycle_too_fast_o(cycle_too_fast_o),
        .ch_out_en_o(ch_out_en_o), .ch_led_o(ch_led_o), .err_led_o(err_led_o));

    scm_ctrl_model i_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .idx_i(idx),
        .cycle_start_o(cycle_start_i), .rd_stb_o(rd_stb_i), .rd_idx_o(rd_idx_i));

    // ----------------------------------------------------------------
    // Clock, comparison and closing report
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Monitor: each answer consumes the oldest queued expectation
    always @(negedge clk_i) begin
        if (rd_ack_o === 1'b1) begin
            if (exp_q.size() == 0)
                check(16'h0100, 16'h0000);
            else
                check(rd_data_o, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    task automatic bus_cycle(input logic [7:0] i, input logic [7:0] exp);
        int k;
        exp_q.push_back(exp);
        idx <= i;
        go <= 1'b1;
        @(negedge clk_i);
        go <= 1'b0;
        // Bounded wait for the answer to retire the note
        for (k = 0; k < 12 && exp_q.size() != 0; k++)
            @(negedge clk_i);
        if (exp_q.size() != 0) begin
            check(16'h0200, 16'h0000);
            summarize();
        end
    endtask

    // Count lit cycles of one indicator over a window
    task automatic count_lit(input int sel, input int len, output int cnt);
        cnt = 0;
        repeat (len) begin
            @(negedge clk_i);
            if ((sel < 0) ? (err_led_o === 1'b1) : (ch_led_o[sel] === 1'b1))
                cnt++;
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst_i = 1'b0;
        ch_short_i = 4'h0;
        ch_open_i = 4'h0;
        module_error_i = 1'b0;
        fixed_ctrl_i = 1'b1;
        go = 1'b0;
        idx = 8'h00;
        repeat (6) @(negedge clk_i);
        check(err_led_o, 1'b1);
        check(can_slots_o, 8'h00);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(can_slots_o, SLOTS_ON_CAN);
        check(func_model_o, 8'hfe);
        fixed_ctrl_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(func_model_o, 8'h00);
        check(err_led_o, 1'b0);
        check({ch_led_o, ch_out_en_o}, 8'hff);
        // Random channel conditions, each read after a full update period
        repeat (10) begin
            a = 8'($random(seed));
            ch_short_i = a[3:0];
            ch_open_i = a[7:4];
            repeat (UPD + 5) @(negedge clk_i);
            bus_cycle(8'h00, a);
            bus_cycle(8'({$random(seed)} % 255 + 1), 8'h00);
        end
        // Second cycle too soon: snapshot held and fast cycle flagged
        a = 8'h3c;
        b = 8'hc3;
        {ch_open_i, ch_short_i} = a;
        repeat (UPD + 5) @(negedge clk_i);
        bus_cycle(8'h00, a);
        {ch_open_i, ch_short_i} = b;
        bus_cycle(8'h00, a);
        check(cycle_too_fast_o, 1'b1);
        repeat (MIN_CYCLE_CYCLES) @(negedge clk_i);
        bus_cycle(8'h00, b);
        check(cycle_too_fast_o, 1'b0);
        // Indicators: open, overloaded and normal channels together
        ch_open_i = 4'h1;
        ch_short_i = 4'h2;
        repeat (2) @(negedge clk_i);
        check(ch_led_o[0], 1'b0);
        check(ch_led_o[3:2], 2'b11);
        check(ch_out_en_o, 4'hd);
        count_lit(1, 2 * BLINK_HALF_TICKS * TICK, n);
        check(16'(n), 16'(BLINK_HALF_TICKS * TICK));
        count_lit(-1, FLASH_PERIOD_TICKS * TICK, n);
        check(16'(n), 16'(FLASH_ON_TICKS * TICK));
        module_error_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(err_led_o, 1'b1);
        module_error_i = 1'b0;
        ch_short_i = 4'h0;
        repeat (2) @(negedge clk_i);
        check(err_led_o, 1'b0);
        // Reset in mid-run lights the error indicator again
        nrst_i = 1'b0;
        @(negedge clk_i);
        check(err_led_o, 1'b1);
        check(can_slots_o, 8'h00);
        // Release with an open line only; the first cycle refreshes at once
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(err_led_o, 1'b0);
        check(ch_led_o, 4'he);
        bus_cycle(8'h00, 8'h10);
        summarize();
    end
endmodule
